// ---- rtl/resr_cfg.svh ----
`ifndef RESR_CFG_SVH
`define RESR_CFG_SVH

// ==========================================================================
// register offsets
`define RESR_ADDR_EVENT 8'h00
`define RESR_ADDR_LIVE 8'h01

// ==========================================================================
// reset values
`define RESR_EVENT_RESET 8'h00
`define RESR_LIVE_RESET 8'h00
`define RESR_RDATA_RESET 8'h00
`define RESR_UNMAPPED_DATA 8'h00

// ==========================================================================
// bit positions, shared by both registers
`define RESR_BIT_PG 0
`define RESR_BIT_OC 1
`define RESR_BIT_UV 2
`define RESR_BIT_SC 3
`define RESR_BIT_SPARE 4
`define RESR_BIT_TPREW 5
`define RESR_BIT_TWARN 6
`define RESR_BIT_TSD 7

`endif

// ---- rtl/resr_pkg.sv ----
package resr_pkg;

  // ========================================================================
  // raw conditions from the analog detectors
  typedef struct packed {
    logic thermal_shutdown_live;
    logic thermal_warn_live;
    logic thermal_prewarn_live;
    logic short_circuit_live;
    logic undervoltage_live;
    logic overcurrent_live;
    logic power_good_live;
  } resr_raw_t;

  // ========================================================================
  // register image, bit 4 spare
  typedef struct packed {
    logic thermal_shutdown;
    logic thermal_warn;
    logic thermal_prewarn;
    logic spare;
    logic short_circuit;
    logic undervoltage;
    logic overcurrent;
    logic power_good;
  } resr_reg_t;

  // ========================================================================
  // host read port
  typedef struct packed {
    logic en;
    logic [7:0] addr;
  } resr_rd_req_t;

endpackage : resr_pkg

// ---- rtl/resr_sync.sv ----
module resr_sync
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // asynchronous conditions in, synchronised out
  input wire resr_pkg::resr_raw_t raw_in,
  output resr_pkg::resr_raw_t raw_sync
);

  resr_pkg::resr_raw_t meta;
  resr_pkg::resr_raw_t next_meta;
  resr_pkg::resr_raw_t next_sync;

  // ========================================================================
  // two-stage synchroniser, first stage feeds only the second
  always_comb
  begin
    next_meta = raw_in;
    next_sync = meta;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta <= '0;
      raw_sync <= '0;
    end
    else
    begin
      meta <= next_meta;
      raw_sync <= next_sync;
    end
  end

endmodule : resr_sync

// ---- rtl/resr_status_regs.sv ----
// Summary of operation
// - event register reads 1 for latched events; a read of the event register clears it
// - over-current event latches into event register bit 1
// - input under-voltage event latches into event register bit 2
// - short-circuit protection event latches into event register bit 3
// - thermal prewarn bit 5, warn bit 6, shutdown bit 7; power good bit 0
// - live bit 1 shows current over limit, 0 below
// - live bit 6 shows junction over thermal warning limit
// - live bit 7 shows junction over thermal shutdown limit
`include "resr_cfg.svh"

module resr_status_regs
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // raw detector conditions, asynchronous to clk
  input wire resr_pkg::resr_raw_t cond_raw,
  // register read port from the serial interface
  input wire resr_pkg::resr_rd_req_t rd_req,
  output logic [7:0] rd_data,
  output logic rd_valid
);

  // ========================================================================
  // map the seven conditions onto the register layout
  function automatic resr_pkg::resr_reg_t to_reg(resr_pkg::resr_raw_t r);
    resr_pkg::resr_reg_t v;
    v = '0;
    v.power_good = r.power_good_live;
    v.overcurrent = r.overcurrent_live;
    v.undervoltage = r.undervoltage_live;
    v.short_circuit = r.short_circuit_live;
    v.spare = 1'b0;
    v.thermal_prewarn = r.thermal_prewarn_live;
    v.thermal_warn = r.thermal_warn_live;
    v.thermal_shutdown = r.thermal_shutdown_live;
    return v;
  endfunction : to_reg

  // ========================================================================
  // synchronise detector outputs
  resr_pkg::resr_raw_t cond_sync;

  resr_sync u_sync
  (
    .clk(clk),
    .nrst(nrst),
    .raw_in(cond_raw),
    .raw_sync(cond_sync)
  );

  // ========================================================================
  // live image and event latch
  resr_pkg::resr_reg_t live_condition_reg;
  resr_pkg::resr_reg_t event_latch_reg;
  resr_pkg::resr_reg_t next_live;
  resr_pkg::resr_reg_t next_event;
  resr_pkg::resr_reg_t cond_now;
  resr_pkg::resr_reg_t edge_seen;
  logic [7:0] next_rd_data;
  logic next_rd_valid;
  logic rd_event;
  logic rd_live;

  always_comb
  begin
    cond_now = to_reg(cond_sync);
    // both edges count, so removal of a fault is reported too
    edge_seen = cond_now ^ live_condition_reg;
    edge_seen.spare = 1'b0;
    rd_event = rd_req.en && (rd_req.addr == `RESR_ADDR_EVENT);
    rd_live = rd_req.en && (rd_req.addr == `RESR_ADDR_LIVE);
    next_live = cond_now;
    // a new edge in the clearing cycle survives the clear
    if (rd_event)
    begin
      next_event = edge_seen;
    end
    else
    begin
      next_event = event_latch_reg | edge_seen;
    end
    next_rd_valid = rd_req.en;
    next_rd_data = rd_data;
    if (rd_req.en)
    begin
      case (rd_req.addr)
        `RESR_ADDR_EVENT:
        begin
          next_rd_data = event_latch_reg;
        end
        `RESR_ADDR_LIVE:
        begin
          next_rd_data = live_condition_reg;
        end
        default:
        begin
          next_rd_data = `RESR_UNMAPPED_DATA;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      live_condition_reg <= `RESR_LIVE_RESET;
      event_latch_reg <= `RESR_EVENT_RESET;
      rd_data <= `RESR_RDATA_RESET;
      rd_valid <= 1'b0;
    end
    else
    begin
      live_condition_reg <= next_live;
      event_latch_reg <= next_event;
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

  // ========================================================================
  // checks
  read_returns_flags_a: assert property (
    @(posedge clk) disable iff (!nrst)
    rd_event |=> (rd_data == $past(event_latch_reg)) && rd_valid
  ) else $error("event read did not return latched flags");

  read_clears_a: assert property (
    @(posedge clk) disable iff (!nrst)
    rd_event |=> event_latch_reg == $past(edge_seen)
  ) else $error("event read did not clear flags");

  overcurrent_latch_a: assert property (
    @(posedge clk) disable iff (!nrst)
    $changed(cond_sync.overcurrent_live)
      |=> event_latch_reg[`RESR_BIT_OC]
  ) else $error("over-current edge not latched in bit 1");

  undervoltage_latch_a: assert property (
    @(posedge clk) disable iff (!nrst)
    $changed(cond_sync.undervoltage_live)
      |=> event_latch_reg[`RESR_BIT_UV]
  ) else $error("under-voltage edge not latched in bit 2");

  short_latch_a: assert property (
    @(posedge clk) disable iff (!nrst)
    $changed(cond_sync.short_circuit_live)
      |=> event_latch_reg[`RESR_BIT_SC]
  ) else $error("short-circuit edge not latched in bit 3");

  thermal_latch_a: assert property (
    @(posedge clk) disable iff (!nrst)
    $changed(cond_sync.thermal_shutdown_live)
      |=> event_latch_reg[`RESR_BIT_TSD]
  ) else $error("thermal shutdown edge not latched in bit 7");

  overcurrent_live_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ##1 live_condition_reg[`RESR_BIT_OC] == $past(cond_sync.overcurrent_live)
  ) else $error("live bit 1 does not follow over-current");

  twarn_live_a: assert property (
    @(posedge clk) disable iff (!nrst)
    rd_live |=> rd_data[`RESR_BIT_TWARN]
      == $past(live_condition_reg.thermal_warn)
  ) else $error("live bit 6 read wrong");

  tsd_live_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ##1 live_condition_reg[`RESR_BIT_TSD]
      == $past(cond_sync.thermal_shutdown_live)
  ) else $error("live bit 7 does not follow thermal shutdown");

  falling_edge_a: assert property (
    @(posedge clk) disable iff (!nrst)
    $fell(cond_sync.power_good_live) |=> event_latch_reg.power_good
  ) else $error("falling power-good edge not latched");

  live_read_quiet_a: assert property (
    @(posedge clk) disable iff (!nrst)
    rd_live |=> event_latch_reg
      == ($past(event_latch_reg) | $past(edge_seen))
  ) else $error("live read disturbed event flags");

  spare_zero_a: assert property (
    @(posedge clk) disable iff (!nrst)
    rd_valid |-> !rd_data[`RESR_BIT_SPARE]
  ) else $error("spare bit read as one");

  pg_rise_latch_a: assert property (
    @(posedge clk) disable iff (!nrst)
    $rose(cond_sync.power_good_live) |=> event_latch_reg.power_good
  ) else $error("power-good edge not latched in bit 0");

  prewarn_latch_a: assert property (
    @(posedge clk) disable iff (!nrst)
    $changed(cond_sync.thermal_prewarn_live)
      |=> event_latch_reg[`RESR_BIT_TPREW]
  ) else $error("thermal prewarn edge not latched in bit 5");

  warn_latch_a: assert property (
    @(posedge clk) disable iff (!nrst)
    $changed(cond_sync.thermal_warn_live)
      |=> event_latch_reg[`RESR_BIT_TWARN]
  ) else $error("thermal warn edge not latched in bit 6");

  read_valid_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ##1 rd_valid == $past(rd_req.en)
  ) else $error("read valid not one cycle after request");

  flags_hold_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !rd_event |=> (event_latch_reg & $past(event_latch_reg))
      == $past(event_latch_reg)
  ) else $error("event flag lost without a read");

  rdata_hold_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !rd_req.en |=> $stable(rd_data)
  ) else $error("read data changed without a request");

  spare_reg_zero_a: assert property (
    @(posedge clk) disable iff (!nrst)
    !live_condition_reg.spare && !event_latch_reg.spare
  ) else $error("spare bit set in a register");

endmodule : resr_status_regs

// ---- verification/resr_host_model.sv ----
// ==========================================================================
// host side: issues single register reads on the read port
module resr_host_model
(
  // clock
  input wire logic clk,
  // read port toward the status registers
  output resr_pkg::resr_rd_req_t rd_req,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    rd_req.en = 1'b0;
    rd_req.addr = 8'hff;
  end

  // one-cycle request, answer registered on the taking edge and sampled half a cycle later
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
                          output logic ok);
    @(negedge clk);
    rd_req.addr = addr;
    rd_req.en = 1'b1;
    @(negedge clk);
    rd_req.en = 1'b0;
    // idle address inverted so a stale decode cannot look correct
    rd_req.addr = ~addr;
    ok = rd_valid;
    data = rd_data;
  endtask : read_reg
endmodule : resr_host_model

// ---- verification/testbench.sv ----
// ==========================================================================
// status register testbench
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk;
  logic nrst;
  resr_pkg::resr_raw_t cond_raw;
  resr_pkg::resr_rd_req_t rd_req;
  logic [7:0] rd_data;
  logic rd_valid;
  int errors;
  int total_checks;

  initial clk = 1'b0;
  always #50 clk = ~clk;

  resr_status_regs u_resr_status_regs (
    .clk(clk),
    .nrst(nrst),
    .cond_raw(cond_raw),
    .rd_req(rd_req),
    .rd_data(rd_data),
    .rd_valid(rd_valid)
  );

  resr_host_model u_resr_host_model (
    .clk(clk),
    .rd_req(rd_req),
    .rd_data(rd_data),
    .rd_valid(rd_valid)
  );

  // ========================================================================
  // checking and closing
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask : chk

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_resr_host_model.read_reg(addr, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, exp);
  endtask : rd

  // detector path needs three edges; five leaves margin
  task automatic settle;
    repeat (5) @(negedge clk);
  endtask : settle

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  // ========================================================================
  // main sequence
  initial
  begin
    int b;
    logic [7:0] m;
    errors = 0;
    total_checks = 0;
    cond_raw = '0;
    nrst = 1'b0;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    for (int j = 0; j < 7; j++)
    begin
      b = (j < 4) ? j : j + 1;
      m = 8'h01 << b;
      cond_raw[j] = 1'b1;
      settle();
      rd(8'h01, m);
      rd(8'h01, m);
      rd(8'h00, m);
      rd(8'h00, 8'h00);
      cond_raw[j] = 1'b0;
      settle();
      rd(8'h00, m);
      rd(8'h01, 8'h00);
    end
    cond_raw = 7'h7f;
    settle();
    rd(8'h01, 8'hef);
    rd(8'h00, 8'hef);
    rd(8'h00, 8'h00);
    // reset in mid-run with every condition still present
    nrst = 1'b0;
    settle();
    nrst = 1'b1;
    rd(8'h00, 8'h00);
    settle();
    rd(8'h00, 8'hef);
    stop_test();
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    stop_test();
  end
endmodule : testbench
